// *** inc/trigger_pipeline_pkg.sv ***
package trigger_pipeline_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Structure
    localparam int CHANNELS = 64;
    localparam int TS_WIDTH = 30;
    localparam int PIPE_DEPTH = 512;
    localparam int WIDE_WINDOW = 8;

    ////////////////////////////////////////////////////////////////////////
    // Register port
    localparam int ADDR_WIDTH = 5;
    localparam int DATA_WIDTH = 32;
    localparam logic [4:0] CONTROL_ADDR = 5'h00;
    localparam logic [4:0] MASK_LOW_ADDR = 5'h04;
    localparam logic [4:0] MASK_HIGH_ADDR = 5'h08;
    localparam logic [4:0] STATUS_ADDR = 5'h0c;
    localparam logic [4:0] ACCEPT_COUNT_ADDR = 5'h10;

    ////////////////////////////////////////////////////////////////////////
    // Control fields and reset values
    localparam int CONTROL_WIDTH = 3;
    localparam int MULTIPLICITY_BIT = 0;
    localparam int WINDOW_BIT = 1;
    localparam int SOURCE_BIT = 2;
    localparam logic [2:0] CONTROL_RESET = 3'h0;
    localparam logic [63:0] MASK_RESET = 64'hffff_ffff_ffff_ffff;
    localparam logic [31:0] ACCEPT_COUNT_RESET = 32'h0000_0000;

endpackage

// *** design/hit_trigger_pipeline.sv ***
`timescale 1ns/1ps

// What this block does
// - Register every discriminator output each rising edge
// - Crossing shows as hit next cycle
// - One hit per crossing, no time-over-threshold
// - Crossing at the capture edge never lost
// - Sixty-four independent channels throughout
// - Per-channel mask ANDs every registered hit
// - Accept on one, or two-plus, hit channels
// - Window select picks one or eight cycles
// - Fresh accept decision on every clock edge
// - Decision latency runs parallel to pipeline
// - Half-period trigger pulse per accept cycle
// - Pipeline carries hits with timestamp bits
// - Shift register, every stage moves each edge
// - Pipeline delay exactly 512 cycles
// - Output word kept only on second-level accept
// - Source select: delayed internal or external accept
module hit_trigger_pipeline #(
    parameter int TS_WIDTH = trigger_pipeline_pkg::TS_WIDTH,
    parameter int PIPE_DEPTH = trigger_pipeline_pkg::PIPE_DEPTH,
    parameter int WIDE_WINDOW = trigger_pipeline_pkg::WIDE_WINDOW
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic enable_i,
    input wire logic [trigger_pipeline_pkg::CHANNELS-1:0] disc_i,
    input wire logic [TS_WIDTH-1:0] timestamp_i,
    input wire logic external_trigger_i,
    input wire logic [trigger_pipeline_pkg::ADDR_WIDTH-1:0] reg_addr_i,
    input wire logic [trigger_pipeline_pkg::DATA_WIDTH-1:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [trigger_pipeline_pkg::DATA_WIDTH-1:0] reg_rdata_o,
    output logic first_level_accept_o,
    output wire logic trigger_output_pulse_o,
    output logic readout_write_o,
    output logic [trigger_pipeline_pkg::CHANNELS+TS_WIDTH-1:0] readout_data_o
);

    localparam int CH = trigger_pipeline_pkg::CHANNELS;
    localparam int WORD = CH + TS_WIDTH;

    function automatic logic at_least_two(input logic [CH-1:0] v);
        at_least_two = |(v & (v - {{(CH-1){1'b0}}, 1'b1}));
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Registers reached over the plain port
    logic [2:0] control;
    logic [63:0] mask;
    logic [31:0] accept_count;
    logic [31:0] read_value;
    logic multiplicity_select;
    logic window_select;
    logic accept_source_select;
    logic second_level_accept;

    assign multiplicity_select =
        control[trigger_pipeline_pkg::MULTIPLICITY_BIT];
    assign window_select = control[trigger_pipeline_pkg::WINDOW_BIT];
    assign accept_source_select = control[trigger_pipeline_pkg::SOURCE_BIT];

    assign read_value =
        (reg_addr_i == trigger_pipeline_pkg::CONTROL_ADDR) ?
            {29'h0000_0000, control} :
        (reg_addr_i == trigger_pipeline_pkg::MASK_LOW_ADDR) ? mask[31:0] :
        (reg_addr_i == trigger_pipeline_pkg::MASK_HIGH_ADDR) ? mask[63:32] :
        (reg_addr_i == trigger_pipeline_pkg::STATUS_ADDR) ?
            {30'h0000_0000, first_level_accept_o, readout_write_o} :
        (reg_addr_i == trigger_pipeline_pkg::ACCEPT_COUNT_ADDR) ?
            accept_count :
        32'h0000_0000;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            control <= trigger_pipeline_pkg::CONTROL_RESET;
            mask <= trigger_pipeline_pkg::MASK_RESET;
            reg_rdata_o <= 32'h0000_0000;
        end else if (enable_i) begin
            if (reg_write_i &&
                reg_addr_i == trigger_pipeline_pkg::CONTROL_ADDR) begin
                control <= reg_wdata_i[2:0];
            end
            if (reg_write_i &&
                reg_addr_i == trigger_pipeline_pkg::MASK_LOW_ADDR) begin
                mask[31:0] <= reg_wdata_i;
            end
            if (reg_write_i &&
                reg_addr_i == trigger_pipeline_pkg::MASK_HIGH_ADDR) begin
                mask[63:32] <= reg_wdata_i;
            end
            reg_rdata_o <= reg_read_i ? read_value : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Hit capture
    logic [CH-1:0] disc_q;
    logic [CH-1:0] hit_raw;
    logic [CH-1:0] hit_masked;

    // Rising edge of the level gives a single-cycle hit per crossing
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            disc_q <= {CH{1'b0}};
            hit_raw <= {CH{1'b0}};
        end else if (enable_i) begin
            disc_q <= disc_i;
            hit_raw <= disc_i & ~disc_q;
        end
    end

    assign hit_masked = hit_raw & mask;

    ////////////////////////////////////////////////////////////////////////
    // First-level decision
    logic [CH-1:0] history [WIDE_WINDOW-1];
    logic [CH-1:0] history_or;
    logic [CH-1:0] window_hits;
    logic next_accept;

    always_comb begin
        history_or = {CH{1'b0}};
        for (int i = 0; i < WIDE_WINDOW - 1; i++) begin
            history_or = history_or | history[i];
        end
    end

    assign window_hits = window_select ?
        (hit_masked | history_or) : hit_masked;
    assign next_accept = multiplicity_select ?
        at_least_two(window_hits) : |window_hits;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            for (int i = 0; i < WIDE_WINDOW - 1; i++) begin
                history[i] <= {CH{1'b0}};
            end
            first_level_accept_o <= 1'b0;
        end else if (enable_i) begin
            history[0] <= hit_masked;
            for (int i = 1; i < WIDE_WINDOW - 1; i++) begin
                history[i] <= history[i-1];
            end
            first_level_accept_o <= next_accept;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Trigger pulse: high from a rising edge to the next falling edge
    logic pulse_toggle;
    logic pulse_echo;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pulse_toggle <= 1'b0;
        end else if (enable_i) begin
            pulse_toggle <= pulse_toggle ^ next_accept;
        end
    end

    always_ff @(negedge clk_i) begin
        if (reset_i) begin
            pulse_echo <= 1'b0;
        end else begin
            pulse_echo <= pulse_toggle;
        end
    end

    // Each accept cycle gives a fresh rising edge for the receiver
    assign trigger_output_pulse_o = pulse_toggle ^ pulse_echo;

    ////////////////////////////////////////////////////////////////////////
    // Delay pipeline and second-level selection
    logic [WORD-1:0] pipe [PIPE_DEPTH];
    logic [WORD-1:0] pipe_word;
    logic [PIPE_DEPTH-2:0] accept_delay;

    assign pipe_word = {timestamp_i, hit_masked};

    always_ff @(posedge clk_i) begin
        if (enable_i) begin
            pipe[0] <= pipe_word;
            for (int i = 1; i < PIPE_DEPTH; i++) begin
                pipe[i] <= pipe[i-1];
            end
        end
    end

    // Accept is one cycle late, so its delay line is one stage short
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            accept_delay <= {(PIPE_DEPTH-1){1'b0}};
        end else if (enable_i) begin
            accept_delay <= {accept_delay[PIPE_DEPTH-3:0],
                             first_level_accept_o};
        end
    end

    assign second_level_accept = accept_source_select ?
        external_trigger_i : accept_delay[PIPE_DEPTH-2];

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            readout_write_o <= 1'b0;
            readout_data_o <= {WORD{1'b0}};
            accept_count <= trigger_pipeline_pkg::ACCEPT_COUNT_RESET;
        end else if (enable_i) begin
            readout_write_o <= second_level_accept;
            if (second_level_accept) begin
                readout_data_o <= pipe[PIPE_DEPTH-1];
                accept_count <= accept_count + 32'h0000_0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_hit_single_shot: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (enable_i && disc_i == disc_q) |=> (hit_raw == {CH{1'b0}}))
        else $error("hit repeated on steady discriminator level");

    a_hit_next_cycle: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (enable_i && (disc_i & ~disc_q) != {CH{1'b0}}) |=>
        ((hit_raw & $past(disc_i)) == $past(disc_i & ~disc_q)))
        else $error("crossing missing from next cycle hit");

    a_mask_gates_hit: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (hit_masked & ~mask) == {CH{1'b0}})
        else $error("masked channel produced a hit");

    a_single_accept: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (enable_i && !multiplicity_select && !window_select &&
         |hit_masked) |=> first_level_accept_o)
        else $error("single hit did not give accept");

    a_pair_required: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (enable_i && multiplicity_select && !window_select &&
         !at_least_two(hit_masked)) |=> !first_level_accept_o)
        else $error("accept without two channels");

    a_wide_window_hold: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (enable_i && window_select && !multiplicity_select &&
         |hit_masked) ##1
        (enable_i && window_select && !multiplicity_select)[*7] |=>
        first_level_accept_o)
        else $error("hit dropped from eight cycle window");

    a_pulse_edge_follows: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (enable_i && next_accept) |=>
        (pulse_toggle != $past(pulse_toggle) && first_level_accept_o))
        else $error("accept gave no trigger pulse edge");

    a_pipe_shifts: assert property (
        @(posedge clk_i) disable iff (reset_i)
        enable_i |=> (pipe[1] == $past(pipe[0]) &&
                      pipe[0] == $past(pipe_word)))
        else $error("pipeline stage did not advance");

    a_drop_on_reject: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (enable_i && !second_level_accept) |=>
        (!readout_write_o && $stable(readout_data_o)))
        else $error("rejected word reached readout");

    a_external_source: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (enable_i && accept_source_select && external_trigger_i) |=>
        (readout_write_o && readout_data_o == $past(pipe[PIPE_DEPTH-1])))
        else $error("external accept did not keep the word");

endmodule

// *** sim/level1_trigger_model.sv ***
`timescale 1ns/1ps

module level1_trigger_model #(
    parameter int LATENCY = 15
) (
    input wire logic clk_i,
    input wire logic pulse_i,
    input wire logic answer_i,
    output logic accept_o
);
    int unsigned n_rises = 0;
    int unsigned n_seen = 0;
    logic seen = 1'b0;
    logic [LATENCY-2:0] history = '0;

    initial accept_o = 1'b0;

    always @(posedge pulse_i) n_rises++;

    // Half period after the edge, so the pulse edge is never raced
    always @(negedge clk_i) begin
        seen = (n_rises != n_seen) && answer_i;
        n_seen = n_rises;
    end

    always @(posedge clk_i) begin
        history <= {history[LATENCY-3:0], seen};
        accept_o <= history[LATENCY-2];
    end
endmodule

// *** sim/tb.sv ***
`timescale 1ns/1ps

module tb;
    localparam int P = 16;
    localparam int W = 94;
    logic clk_i = 0, reset_i = 1, enable_i = 1, answer = 1;
    logic [63:0] disc = '0;
    logic [29:0] ts = '0;
    logic [4:0] addr = '0;
    logic [31:0] wdata = '0;
    logic wr = 0, rd = 0;
    wire [31:0] rdata;
    wire accept, pulse, rw, ext;
    wire [W-1:0] rdat;
    int n_errors = 0, samples_checked = 0, cycles = 0, acc = 0;

    hit_trigger_pipeline #(.PIPE_DEPTH(P)) u_hit_trigger_pipeline (
        .clk_i(clk_i), .reset_i(reset_i), .enable_i(enable_i),
        .disc_i(disc), .timestamp_i(ts), .external_trigger_i(ext),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_write_i(wr),
        .reg_read_i(rd), .reg_rdata_o(rdata),
        .first_level_accept_o(accept), .trigger_output_pulse_o(pulse),
        .readout_write_o(rw), .readout_data_o(rdat));

    level1_trigger_model #(.LATENCY(P - 1)) u_level1_trigger_model (
        .clk_i(clk_i), .pulse_i(pulse), .answer_i(answer), .accept_o(ext));

    ////////////////////////////////////////////////////////////////////////
    initial forever #20 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        ts <= ts + 30'h1;
        acc += accept;
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [W-1:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic reg_write(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [4:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic ctrl(input logic m, w, s);
        reg_write(trigger_pipeline_pkg::CONTROL_ADDR, {29'h0, s, w, m});
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [31:0] v;
        reg_read(trigger_pipeline_pkg::CONTROL_ADDR, v);
        chk(v, 32'h0);
        reg_read(trigger_pipeline_pkg::MASK_LOW_ADDR, v);
        chk(v, 32'hffff_ffff);
        reg_read(trigger_pipeline_pkg::MASK_HIGH_ADDR, v);
        chk(v, 32'hffff_ffff);
        reg_read(5'h14, v);
        chk(v, 32'h0);
    endtask

    // Raise a, then b gap cycles later, and count accepts
    task automatic run_case(input logic [63:0] a, b, input int gap, exp);
        #1 acc = 0;
        @(posedge clk_i);
        disc <= a;
        repeat (gap) @(posedge clk_i);
        disc <= a | b;
        repeat (12) @(posedge clk_i);
        disc <= '0;
        repeat (24) @(posedge clk_i);
        #1 chk(acc, exp);
    endtask

    task automatic t_path(input logic [63:0] d, hits, input logic keep);
        logic [31:0] c0, c1;
        logic [29:0] ts_h;
        reg_read(trigger_pipeline_pkg::ACCEPT_COUNT_ADDR, c0);
        @(posedge clk_i);
        disc <= d;
        @(posedge clk_i);
        #1 ts_h = ts;
        @(posedge clk_i);
        #1 chk(accept, 1'b1);
        chk(pulse, 1'b1);
        #25 chk(pulse, 1'b0);
        @(posedge clk_i);
        #1 chk(accept, 1'b0);
        repeat (P - 2) begin
            @(posedge clk_i);
            #1 chk(rw, 1'b0);
        end
        @(posedge clk_i);
        #1 chk(rw, keep);
        if (keep)
            chk(rdat, {ts_h, hits});
        @(posedge clk_i);
        #1 chk(rw, 1'b0);
        @(posedge clk_i);
        disc <= '0;
        reg_read(trigger_pipeline_pkg::ACCEPT_COUNT_ADDR, c1);
        chk(c1 - c0, {31'h0, keep});
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        t_regs();
        run_case(64'h20, 64'h20, 1, 1);
        run_case(64'h1, 64'h8000_0000_0000_0000, 1, 2);
        ctrl(1'b1, 1'b0, 1'b0);
        run_case(64'h1, 64'h2, 1, 0);
        run_case(64'h3, 64'h3, 1, 1);
        ctrl(1'b0, 1'b1, 1'b0);
        run_case(64'h10, 64'h10, 1, 8);
        ctrl(1'b1, 1'b1, 1'b0);
        run_case(64'h1, 64'h2, 7, 1);
        run_case(64'h1, 64'h2, 8, 0);
        ctrl(1'b0, 1'b0, 1'b0);
        reg_write(trigger_pipeline_pkg::MASK_HIGH_ADDR, 32'h7fff_ffff);
        run_case(64'h8000_0000_0000_0000, 64'h0, 1, 0);
        reg_write(trigger_pipeline_pkg::MASK_HIGH_ADDR, 32'hffff_ffff);
        reg_write(trigger_pipeline_pkg::MASK_LOW_ADDR, 32'hffff_ffdf);
        t_path(64'h60, 64'h40, 1'b1);
        reg_write(trigger_pipeline_pkg::MASK_LOW_ADDR, 32'hffff_ffff);
        ctrl(1'b0, 1'b0, 1'b1);
        t_path(64'h20, 64'h20, 1'b1);
        answer <= 1'b0;
        t_path(64'h20, 64'h20, 1'b0);
        complete_run();
    end
endmodule
